//--- design/rmi_regs.vh
// constants, offsets and timing figures of the remote input function block
`ifndef RMI_REGS_VH
`define RMI_REGS_VH
// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define RMI_OFS_MODE0    6'h00
`define RMI_OFS_MODE1    6'h04
`define RMI_OFS_MODE2    6'h08
`define RMI_OFS_MODE3    6'h0c
`define RMI_OFS_MODEB    6'h10
`define RMI_OFS_LEVEL    6'h14
`define RMI_OFS_DIM      6'h18
`define RMI_OFS_RT_LO    6'h1c
`define RMI_OFS_RT_HI    6'h20
`define RMI_OFS_STATUS   6'h24
// ----------------------------------------------------------------------
// reset values and field layouts
// ----------------------------------------------------------------------
`define RMI_RST_MODE     4'h0
`define RMI_RST_LEVEL    5'h10
`define RMI_RST_DIM      6'h07
`define RMI_RST_RT_LO    16'h0000
`define RMI_RST_RT_HI    16'h03e8
`define RMI_MODE_W       4
`define RMI_DIM_MAX      6'h3f
// ----------------------------------------------------------------------
// function codes
// ----------------------------------------------------------------------
`define RMI_M_NONE       4'h0
`define RMI_M_PEAK_HOLD  4'h1
`define RMI_M_FREEZE     4'h2
`define RMI_M_MAX_RECALL 4'h3
`define RMI_M_MIN_RECALL 4'h4
`define RMI_M_TOGGLE     4'h5
`define RMI_M_ALARM_ACK  4'h6
`define RMI_M_SETUP_LOCK 4'h7
`define RMI_M_DIM        4'h8
`define RMI_M_SCAN_HOLD  4'h9
`define RMI_M_OUT_SEL    4'ha
`define RMI_M_ALARM_OFF  4'hb
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RMI_CLK_HZ       40000000
`define RMI_MSG_PERIOD_S 8
`define RMI_MSG_LEN_MS   500
`define RMI_REVERT_S     20
`define RMI_HOLD_S       2
`define RMI_MSG_PERIOD_CYC (`RMI_MSG_PERIOD_S * `RMI_CLK_HZ)
`define RMI_MSG_LEN_CYC  (`RMI_MSG_LEN_MS * (`RMI_CLK_HZ / 1000))
`define RMI_REVERT_CYC   (`RMI_REVERT_S * `RMI_CLK_HZ)
`define RMI_HOLD_CYC     (`RMI_HOLD_S * `RMI_CLK_HZ)
`endif

//--- design/rmi_cond.v
// input conditioner: synchroniser, active level, edge and long-hold detect
`timescale 1ns/1ps
module rmi_cond #(
  parameter [31:0] HOLD_CYC = 32'd80000000  // press length for a hold event
) (
  input  wire clk_in,    // system clock
  input  wire rst_b_in,  // synchronous reset, active low
  input  wire en_in,     // clock enable
  input  wire pin_in,    // raw terminal level
  input  wire level_in,  // 1: high level is active
  output reg  act_out,   // input active
  output reg  rise_out,  // one-cycle pulse on activation
  output reg  held_out   // one-cycle pulse once held for HOLD_CYC
);
  reg        sync_a;  // first stage, read only by sync_b
  reg        sync_b;  // second stage
  reg [31:0] hold_cnt; // cycles the input has been active
  wire       act_now = level_in ? sync_b : ~sync_b;

  // ----------------------------------------------------------------------
  // synchronise, qualify level, detect edge and hold
  // ----------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      // park both stages at the idle level so that no false press
      // follows reset on a low-active input
      sync_a   <= ~level_in;
      sync_b   <= ~level_in;
      act_out  <= 1'b0;
      rise_out <= 1'b0;
      held_out <= 1'b0;
      hold_cnt <= 32'h0000_0000;
    end else if (en_in) begin
      sync_a   <= pin_in;
      sync_b   <= sync_a;
      act_out  <= act_now;
      rise_out <= act_now & ~act_out;
      // one event per press; counter parks at the limit
      if (!act_now) begin
        hold_cnt <= 32'h0000_0000;
        held_out <= 1'b0;
      end else if (hold_cnt != HOLD_CYC) begin
        hold_cnt <= hold_cnt + 32'h0000_0001;
        held_out <= (hold_cnt == HOLD_CYC - 32'h0000_0001);
      end else begin
        held_out <= 1'b0;
      end
    end
  end
endmodule // rmi_cond

//--- design/rmi_top.v
// remote input and push-button function logic with register port
`timescale 1ns/1ps
`include "rmi_regs.vh"
module rmi_top #(
  parameter [31:0] MSG_PERIOD_CYC = `RMI_MSG_PERIOD_CYC, // message repeat
  parameter [31:0] MSG_LEN_CYC    = `RMI_MSG_LEN_CYC,    // message length
  parameter [31:0] REVERT_CYC     = `RMI_REVERT_CYC,     // recall timeout
  parameter [31:0] HOLD_CYC       = `RMI_HOLD_CYC        // clear / button hold
) (
  input  wire        clk_in,          // 40 MHz system clock
  input  wire        rst_b_in,        // synchronous reset, active low
  input  wire        en_in,           // clock enable, freezes all state
  input  wire [3:0]  rin_in,          // remote input terminals 1..4
  input  wire        button_in,       // front button, raw
  input  wire [2:0]  view_chan_in,    // channel being viewed
  input  wire [5:0]  norm_bright_in,  // normal brightness level
  input  wire [5:0]  addr_in,         // register byte address
  input  wire [31:0] wdata_in,        // write data
  input  wire        wr_in,           // write strobe
  input  wire        rd_in,           // read strobe
  output reg  [31:0] rdata_out,       // read data, cycle after rd_in
  output reg         peak_hold_out,   // displays may rise only
  output reg         disp_freeze_out, // displays frozen
  output reg         show_max_out,    // show stored maximum
  output reg         show_min_out,    // show stored minimum
  output reg         clear_max_out,   // pulse: clear maximum memory
  output reg         clear_min_out,   // pulse: clear minimum memory
  output reg         ind_max_out,     // flash peak indicator
  output reg         ind_min_out,     // flash valley indicator
  output reg         reset_msg_out,   // show memory reset message
  output reg         peak_msg_out,    // show peak hold message
  output reg         freeze_msg_out,  // show display hold message
  output reg         scan_msg_out,    // show scan hold message
  output reg         alarm_ack_out,   // pulse: acknowledge all alarms
  output reg         setup_allow_out, // setup access permitted
  output reg  [5:0]  bright_out,      // brightness level to use
  output reg         scan_freeze_out, // stop channel scanning
  output reg  [3:0]  out_chan_out,    // analog output channel code
  output reg  [7:0]  alarm_off_out,   // per channel alarm disable
  output reg  [15:0] rt_lo_out,       // retransmission low value
  output reg  [15:0] rt_hi_out        // retransmission high value
);
  // ----------------------------------------------------------------------
  // decoding helper
  // ----------------------------------------------------------------------
  // or of the flags whose source is set to the given function code
  function any_mode;
    input [19:0] mode_set;
    input [4:0]  flags;
    input [3:0]  code;
    integer k;
    begin
      any_mode = 1'b0;
      for (k = 0; k < 5; k = k + 1) begin
        if (mode_set[k*4 +: 4] == code && flags[k])
          any_mode = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  reg  [19:0] modes;      // four bits per source, button at index 4
  reg  [4:0]  level;      // active level per source
  reg  [5:0]  dim_level;  // dimmed brightness 0..63
  reg  [31:0] msg_cnt;    // message period counter
  reg  [31:0] flash_cnt;  // reset message timer
  reg  [31:0] recall_cnt; // recall timeout
  reg         toggle_min; // next toggle shows minimum
  reg         flash_kind; // 1: minimum indicator flashing
  reg         pend_show;  // recall waiting for indicator flash
  wire [4:0]  src_pin;    // raw source levels
  wire [4:0]  act;        // qualified active levels
  wire [4:0]  rise;       // activation pulses
  wire [4:0]  held;       // long-hold pulses
  wire [4:0]  none_mask;  // sources that carry a function

  // button rides at index 4 so that one loop serves all five sources
  assign src_pin = {button_in, rin_in};

  // ----------------------------------------------------------------------
  // per source conditioning
  // ----------------------------------------------------------------------
  // every source has its own synchroniser and hold timer; a shared
  // timer would let one held input hide the press of another
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_src
      rmi_cond #(
        .HOLD_CYC (HOLD_CYC)
      ) u_cond (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .en_in    (en_in),
        .pin_in   (src_pin[g]),
        .level_in (level[g]),
        .act_out  (act[g]),
        .rise_out (rise[g]),
        .held_out (held[g])
      );
      // a source set to none is masked off everywhere
      assign none_mask[g] = (modes[g*4 +: 4] != `RMI_M_NONE);
    end
  endgenerate

  // qualified flags, masked sources never reach a function
  wire [4:0] a_q = act & none_mask;
  wire [4:0] r_q = rise & none_mask;
  wire [4:0] h_q = held & none_mask;

  // ----------------------------------------------------------------------
  // decoded functions
  // ----------------------------------------------------------------------
  // level functions follow the input, edge functions act once a press
  wire hold_on   = any_mode(modes, a_q, `RMI_M_PEAK_HOLD);
  wire freeze_on = any_mode(modes, a_q, `RMI_M_FREEZE);
  wire scan_on   = any_mode(modes, a_q, `RMI_M_SCAN_HOLD);
  wire dim_on    = any_mode(modes, a_q, `RMI_M_DIM);
  wire ack_rise  = any_mode(modes, r_q, `RMI_M_ALARM_ACK);
  wire max_rise  = any_mode(modes, r_q, `RMI_M_MAX_RECALL);
  wire min_rise  = any_mode(modes, r_q, `RMI_M_MIN_RECALL);
  wire tog_rise  = any_mode(modes, r_q, `RMI_M_TOGGLE);
  wire max_act   = any_mode(modes, a_q, `RMI_M_MAX_RECALL);
  wire min_act   = any_mode(modes, a_q, `RMI_M_MIN_RECALL);
  wire tog_act   = any_mode(modes, a_q, `RMI_M_TOGGLE);
  wire max_held  = any_mode(modes, h_q, `RMI_M_MAX_RECALL);
  wire min_held  = any_mode(modes, h_q, `RMI_M_MIN_RECALL);
  wire tog_held  = any_mode(modes, h_q, `RMI_M_TOGGLE);
  wire lock_set  = any_mode(modes, none_mask, `RMI_M_SETUP_LOCK);
  wire lock_on   = any_mode(modes, a_q, `RMI_M_SETUP_LOCK);
  wire msg_any   = hold_on | freeze_on | scan_on;
  // recall is busy while a memory shows or an indicator flashes
  wire recall_on = show_max_out | show_min_out | pend_show;

  // alarm disable: remote inputs toggle on the edge, the button only
  // after a full hold so that a brush of the panel changes nothing
  wire [4:0] off_ev = {h_q[4], r_q[3:0]};
  wire       off_tog = any_mode(modes, off_ev, `RMI_M_ALARM_OFF);

  // binary channel code, bit n from input n+1 in select mode
  // an input in any other mode gives a zero bit
  reg [3:0] next_chan;
  integer   n;
  always @* begin
    next_chan = 4'h0;
    for (n = 0; n < 4; n = n + 1) begin
      if (modes[n*4 +: 4] == `RMI_M_OUT_SEL)
        next_chan[n] = act[n];
    end
  end

  // ----------------------------------------------------------------------
  // register port: writes
  // ----------------------------------------------------------------------
  // only the low bits of a word are kept; the rest read back as zero
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      modes     <= {5{`RMI_RST_MODE}};
      level     <= `RMI_RST_LEVEL;
      dim_level <= `RMI_RST_DIM;
      rt_lo_out <= `RMI_RST_RT_LO;
      rt_hi_out <= `RMI_RST_RT_HI;
    end else if (en_in && wr_in) begin
      case (addr_in)
        `RMI_OFS_MODE0 : modes[3:0]   <= wdata_in[3:0];
        `RMI_OFS_MODE1 : modes[7:4]   <= wdata_in[3:0];
        `RMI_OFS_MODE2 : modes[11:8]  <= wdata_in[3:0];
        `RMI_OFS_MODE3 : modes[15:12] <= wdata_in[3:0];
        `RMI_OFS_MODEB : modes[19:16] <= wdata_in[3:0];
        `RMI_OFS_LEVEL : level        <= wdata_in[4:0];
        `RMI_OFS_DIM   : dim_level    <= wdata_in[5:0];
        `RMI_OFS_RT_LO : rt_lo_out    <= wdata_in[15:0];
        `RMI_OFS_RT_HI : rt_hi_out    <= wdata_in[15:0];
        default        : ;  // read-only or unmapped: ignored
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // register port: reads, data valid the cycle after the strobe
  // ----------------------------------------------------------------------
  // data fall back to zero after one cycle, so a late sample of the
  // port reads zero rather than a stale word
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (en_in) begin
      rdata_out <= 32'h0000_0000;
      if (rd_in) begin
        case (addr_in)
          `RMI_OFS_MODE0  : rdata_out <= {28'h0, modes[3:0]};
          `RMI_OFS_MODE1  : rdata_out <= {28'h0, modes[7:4]};
          `RMI_OFS_MODE2  : rdata_out <= {28'h0, modes[11:8]};
          `RMI_OFS_MODE3  : rdata_out <= {28'h0, modes[15:12]};
          `RMI_OFS_MODEB  : rdata_out <= {28'h0, modes[19:16]};
          `RMI_OFS_LEVEL  : rdata_out <= {27'h0, level};
          `RMI_OFS_DIM    : rdata_out <= {26'h0, dim_level};
          `RMI_OFS_RT_LO  : rdata_out <= {16'h0, rt_lo_out};
          `RMI_OFS_RT_HI  : rdata_out <= {16'h0, rt_hi_out};
          // twenty status bits: channel code, disables, recall, actives
          `RMI_OFS_STATUS : rdata_out <= {12'h0, out_chan_out, alarm_off_out,
                                          show_min_out, show_max_out,
                                          toggle_min, a_q};
          default         : rdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // level functions and periodic messages
  // ----------------------------------------------------------------------
  // one shared period counter: messages show for the first part of
  // every period while any hold type function is active
  // the counter parks at zero while nothing is held, so each new
  // activation opens with its message showing
  // limitation: all hold type messages share one phase
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      msg_cnt         <= 32'h0000_0000;
      peak_hold_out   <= 1'b0;
      disp_freeze_out <= 1'b0;
      scan_freeze_out <= 1'b0;
      peak_msg_out    <= 1'b0;
      freeze_msg_out  <= 1'b0;
      scan_msg_out    <= 1'b0;
      alarm_ack_out   <= 1'b0;
      setup_allow_out <= 1'b1;
      bright_out      <= 6'h00;
      out_chan_out    <= 4'h0;
    end else if (en_in) begin
      peak_hold_out   <= hold_on;
      disp_freeze_out <= freeze_on;
      scan_freeze_out <= scan_on;
      // a single pulse covers every alarm that needs acknowledging
      alarm_ack_out   <= ack_rise;
      // with no lock source configured access stays open
      setup_allow_out <= ~lock_set | lock_on;
      // only the level is picked here; the dimmer itself lies elsewhere
      bright_out      <= dim_on ? dim_level : norm_bright_in;
      out_chan_out    <= next_chan;
      if (!msg_any || msg_cnt == MSG_PERIOD_CYC - 32'h0000_0001)
        msg_cnt <= 32'h0000_0000;
      else
        msg_cnt <= msg_cnt + 32'h0000_0001;
      peak_msg_out   <= hold_on & (msg_cnt < MSG_LEN_CYC);
      freeze_msg_out <= freeze_on & (msg_cnt < MSG_LEN_CYC);
      scan_msg_out   <= scan_on & (msg_cnt < MSG_LEN_CYC);
    end
  end

  // ----------------------------------------------------------------------
  // memory recall, toggle and clearing
  // ----------------------------------------------------------------------
  // toggle flashes its indicator for one message length before the
  // value appears; direct recall modes show at once
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      show_max_out  <= 1'b0;
      show_min_out  <= 1'b0;
      clear_max_out <= 1'b0;
      clear_min_out <= 1'b0;
      ind_max_out   <= 1'b0;
      ind_min_out   <= 1'b0;
      reset_msg_out <= 1'b0;
      toggle_min    <= 1'b0;
      flash_kind    <= 1'b0;
      pend_show     <= 1'b0;
      flash_cnt     <= 32'h0000_0000;
      recall_cnt    <= 32'h0000_0000;
    end else if (en_in) begin
      clear_max_out <= max_held | (tog_held & show_max_out);
      clear_min_out <= min_held | (tog_held & show_min_out);
      if (max_held | min_held | tog_held) begin
        reset_msg_out <= 1'b1;
        flash_cnt     <= MSG_LEN_CYC;
      end else if (flash_cnt != 32'h0000_0000) begin
        flash_cnt <= flash_cnt - 32'h0000_0001;
      end else begin
        reset_msg_out <= 1'b0;
      end
      // a direct recall cancels a pending toggle flash and its indicator
      if (max_rise) begin
        show_max_out <= 1'b1;
        show_min_out <= 1'b0;
        pend_show    <= 1'b0;
        ind_max_out  <= 1'b0;
        ind_min_out  <= 1'b0;
        recall_cnt   <= REVERT_CYC;
      end else if (min_rise) begin
        show_min_out <= 1'b1;
        show_max_out <= 1'b0;
        pend_show    <= 1'b0;
        ind_max_out  <= 1'b0;
        ind_min_out  <= 1'b0;
        recall_cnt   <= REVERT_CYC;
      end else if (tog_rise) begin
        // indicator first, then the chosen memory
        pend_show    <= 1'b1;
        flash_kind   <= toggle_min;
        toggle_min   <= ~toggle_min;
        show_max_out <= 1'b0;
        show_min_out <= 1'b0;
        ind_max_out  <= ~toggle_min;
        ind_min_out  <= toggle_min;
        recall_cnt   <= MSG_LEN_CYC;
      end else if (pend_show) begin
        if (recall_cnt == 32'h0000_0000) begin
          pend_show    <= 1'b0;
          ind_max_out  <= 1'b0;
          ind_min_out  <= 1'b0;
          show_max_out <= ~flash_kind;
          show_min_out <= flash_kind;
          recall_cnt   <= REVERT_CYC;
        end else begin
          recall_cnt <= recall_cnt - 32'h0000_0001;
        end
      end else if (recall_on) begin
        // timeout restarts while the input stays active
        if (max_act | min_act | tog_act)
          recall_cnt <= REVERT_CYC;
        else if (recall_cnt == 32'h0000_0000) begin
          show_max_out <= 1'b0;
          show_min_out <= 1'b0;
        end else
          recall_cnt <= recall_cnt - 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // per channel alarm disable
  // ----------------------------------------------------------------------
  // no software clear exists, so there is no set/clear race here
  // the viewed channel is taken at the toggle edge, not at the press
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      alarm_off_out <= 8'h00;
    end else if (en_in && off_tog) begin
      alarm_off_out[view_chan_in] <= ~alarm_off_out[view_chan_in];
    end
  end
endmodule // rmi_top

//--- tb/rmi_top_assertions.sv
// assertion checker bound to the remote input function block
`timescale 1ns/1ps
module rmi_top_chk (
  input wire        clk_in,
  input wire        rst_b_in,
  input wire        en_in,
  input wire        wr_in,
  input wire [5:0]  addr_in,
  input wire        peak_hold_out,
  input wire        peak_msg_out,
  input wire        disp_freeze_out,
  input wire        freeze_msg_out,
  input wire        show_max_out,
  input wire        show_min_out,
  input wire        ind_max_out,
  input wire        clear_max_out,
  input wire        clear_min_out,
  input wire        reset_msg_out,
  input wire        alarm_ack_out,
  input wire [7:0]  alarm_off_out,
  input wire [15:0] rt_lo_out,
  input wire [15:0] rt_hi_out
);
  // ----------------------------------------------------------------------
  // one clock domain, so one default clock and reset
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  chk_lo_write_only: assert property (
    !$past(en_in && wr_in && addr_in == 6'h1c) |-> $stable(rt_lo_out)) else $error("low moved");
  chk_hi_write_only: assert property (
    !$past(en_in && wr_in && addr_in == 6'h20) |-> $stable(rt_hi_out)) else $error("high moved");
  chk_peak_msg_hold: assert property (
    $rose(peak_msg_out) |-> ##[0:2] peak_hold_out) else $error("peak message without hold");
  chk_freeze_msg: assert property (
    $rose(freeze_msg_out) |-> ##[0:2] disp_freeze_out) else $error("hold message stray");
  chk_clear_msg: assert property (
    clear_max_out || clear_min_out |=> (!clear_max_out && !clear_min_out && reset_msg_out)
    ##1 reset_msg_out [*3]) else $error("clear pulse or reset message wrong");
  chk_show_apart: assert property (
    !(show_max_out && show_min_out)) else $error("peak and valley shown together");
  chk_ind_then_show: assert property (
    $fell(ind_max_out) |-> ##[0:1] show_max_out) else $error("indicator not followed by peak");
  chk_ack_pulse: assert property (
    alarm_ack_out |=> !alarm_ack_out) else $error("acknowledge longer than a cycle");
  chk_one_toggle: assert property (
    $countones(alarm_off_out ^ $past(alarm_off_out)) <= 1) else $error("several alarms flipped");
endmodule // rmi_top_chk
bind rmi_top rmi_top_chk u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .en_in(en_in),
  .wr_in(wr_in), .addr_in(addr_in), .peak_hold_out(peak_hold_out), .peak_msg_out(peak_msg_out),
  .disp_freeze_out(disp_freeze_out), .freeze_msg_out(freeze_msg_out),
  .show_max_out(show_max_out), .show_min_out(show_min_out), .ind_max_out(ind_max_out),
  .clear_max_out(clear_max_out), .clear_min_out(clear_min_out), .reset_msg_out(reset_msg_out),
  .alarm_ack_out(alarm_ack_out), .alarm_off_out(alarm_off_out), .rt_lo_out(rt_lo_out),
  .rt_hi_out(rt_hi_out));

//--- tb/rmi_contacts.sv
// contact closures and front button facing the block
`timescale 1ns/1ps
module rmi_contacts (
  input  wire [4:0] press_in,  // 1 = contact closed or button pressed
  input  wire [4:0] level_in,  // 1 = terminal high while active
  output wire [3:0] rin_out,   // remote terminals 1..4
  output wire       button_out // front button
);
  // idle terminals rest at the inactive level, as the pull resistor holds them
  assign {button_out, rin_out} = ~(press_in ^ level_in);
endmodule // rmi_contacts

//--- tb/tb_rmi_top.sv
// self-checking bench for the remote input function block
`timescale 1ns/1ps
`include "rmi_regs.vh"
module tb_rmi_top;
  reg         clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, en = 1'b1;
  reg  [5:0]  addr_in = 6'h00, nb = 6'h10;  // nb: normal brightness
  reg  [31:0] wdata_in = 32'h0;
  reg  [2:0]  vc = 3'h0;                    // viewed channel
  reg  [4:0]  press = 5'h00, lvl = 5'h10;   // contact intent, active levels
  wire [31:0] rdata;
  wire [15:0] rt_lo, rt_hi;
  wire [7:0]  aoff;
  wire [5:0]  bright;
  wire [3:0]  och, rin;
  wire        ph, pm, df, fm, smx, smn, cmx, cmn, imx, imn, rm, sm, sf, ack, sa, btn;
  wire [8:0]  pb = {rm, cmx | cmn, ack, sm, sf, fm, df, pm, ph};  // probe for counting
  integer     bad_count = 0, cmp_count = 0, i, j, k, n;
  // short counts keep the run brief
  rmi_top #(.MSG_PERIOD_CYC(32'd40), .MSG_LEN_CYC(32'd5), .REVERT_CYC(32'd60),
    .HOLD_CYC(32'd20)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .en_in(en),
    .rin_in(rin), .button_in(btn), .view_chan_in(vc), .norm_bright_in(nb), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .peak_hold_out(ph),
    .disp_freeze_out(df), .show_max_out(smx), .show_min_out(smn), .clear_max_out(cmx),
    .clear_min_out(cmn), .ind_max_out(imx), .ind_min_out(imn), .reset_msg_out(rm),
    .peak_msg_out(pm), .freeze_msg_out(fm), .scan_msg_out(sm), .alarm_ack_out(ack),
    .setup_allow_out(sa), .bright_out(bright), .scan_freeze_out(sf), .out_chan_out(och),
    .alarm_off_out(aoff), .rt_lo_out(rt_lo), .rt_hi_out(rt_hi));
  rmi_contacts u_far (.press_in(press), .level_in(lvl), .rin_out(rin), .button_out(btn));
  // ----------------------------------------------------------------------
  // clock, helpers and bus tasks
  // ----------------------------------------------------------------------
  initial forever #12.5 clk_in = ~clk_in;
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task ck(input [31:0] g, input [31:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("FAIL at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wt(input integer c);  // ends just after an edge, outputs settled
    repeat (c) @(posedge clk_in);
    #1;
  endtask
  task wr(input [5:0] a, input [31:0] d);
    @(posedge clk_in);
    addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input [5:0] a, input [31:0] e);  // data stand only in the cycle after
    @(posedge clk_in);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 ck(rdata, e);
  endtask
  task sm_set(input integer s, input integer m);
    wr({1'b0, s[2:0], 2'b00}, {28'h0, m[3:0]});
  endtask
  task pv(input integer v);
    @(posedge clk_in) press <= v[4:0];
  endtask
  task cn(input integer s, input integer c, output integer t);  // count probe cycles
    t = 0;
    repeat (c) begin
      @(posedge clk_in);
      #1 t = t + pb[s];
    end
  endtask
  // watchdog: the sequence needs well under a tenth of this
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    final_report;
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    wt(1); ck(rt_hi, 32'h3e8); ck(sa, 1);
    for (i = 0; i < 5; i = i + 1) rd({i[3:0], 2'b00}, 0);
    rd(`RMI_OFS_LEVEL, 32'h10); rd(`RMI_OFS_DIM, 32'h7); rd(6'h28, 0);
    rd(`RMI_OFS_RT_LO, 0); rd(`RMI_OFS_RT_HI, 32'h3e8);
    wr(`RMI_OFS_RT_LO, 32'h1234); wr(`RMI_OFS_RT_HI, 32'habcd);
    rd(`RMI_OFS_RT_HI, 32'habcd); wt(1); ck({rt_hi, rt_lo}, 32'habcd1234);
    // with the enable low a write must leave the register alone
    @(posedge clk_in) en <= 1'b0;
    wr(`RMI_OFS_RT_LO, 32'h5555); @(posedge clk_in) en <= 1'b1;
    wt(1); ck(rt_lo, 32'h1234);
    // every source in no-function mode: activity changes nothing
    pv(5'h1f); wt(8); ck({ph, df, smx, smn, imx, imn, pm, fm, sm, sf, ack, och, aoff}, 0);
    ck({sa, bright}, {1'b1, nb}); pv(0); wt(6);
    // peak hold, display hold, scan hold: level plus repeating message
    for (k = 0; k < 3; k = k + 1) begin
      sm_set(0, k == 0 ? 4'h1 : k == 1 ? 4'h2 : 4'h9); pv(1); wt(6);
      cn(2 * k, 80, n); ck(n, 80); cn(2 * k + 1, 80, n); ck(n, 10);
      pv(0); wt(6); ck(pb[2 * k], 0);
    end
    // peak and valley recall: revert after a tap, clear after a long hold
    for (k = 3; k < 5; k = k + 1) begin
      sm_set(0, k); pv(1); wt(3); pv(0); wt(5); ck(k == 3 ? smx : smn, 1);
      wt(45); ck(k == 3 ? smx : smn, 1); wt(25); ck(k == 3 ? smx : smn, 0);
      pv(1); cn(7, 40, n); ck(n, 1); pv(0); wt(80);
    end
    // toggle starts with peak, then valley, indicator first each time
    sm_set(0, 4'h5);
    for (j = 0; j < 2; j = j + 1) begin
      pv(1); wt(2); pv(0); wt(4); ck(j ? imn : imx, 1);
      wt(8); ck({smx, smn}, j ? 2'b01 : 2'b10);
    end
    rd(`RMI_OFS_STATUS, 32'h80);
    sm_set(0, 4'h0); sm_set(1, 4'h6); pv(2); cn(6, 20, n); ck(n, 1); pv(0);
    sm_set(2, 4'h7); wt(6); ck(sa, 0); pv(4); wt(6); ck(sa, 1); pv(0);
    wr(`RMI_OFS_DIM, 32'h3f); rd(`RMI_OFS_DIM, 32'h3f); sm_set(3, 4'h8);
    wt(6); ck(bright, nb); pv(8); wt(6); ck(bright, 32'h3f); pv(0); wt(6); ck(bright, nb);
    // binary channel code with all terminals made high-active
    sm_set(2, 4'h0); sm_set(3, 4'h0); wr(`RMI_OFS_LEVEL, 32'h1f);
    @(posedge clk_in) lvl <= 5'h1f;
    for (i = 0; i < 4; i = i + 1) sm_set(i, 4'ha);
    for (j = 0; j < 4; j = j + 1) begin
      pv(j * 5); wt(6); ck(och, j * 5);
    end
    pv(0);
    for (i = 0; i < 4; i = i + 1) sm_set(i, 4'h0);
    // remote tap toggles at once, the button needs a long press
    @(posedge clk_in) vc <= 3'h3;
    sm_set(0, 4'hb); pv(1); wt(2); pv(0); wt(4); ck(aoff, 32'h08);
    @(posedge clk_in) vc <= 3'h5;
    sm_set(4, 4'hb); pv(5'h10); wt(8); pv(0); wt(6); ck(aoff, 32'h08);
    pv(5'h10); wt(30); pv(0); wt(4); ck(aoff, 32'h28);
    final_report;
  end
endmodule // tb_rmi_top
